// file: pcc_pwm_config.sv
// PWM configuration register, compare/auto-reload access and cycle overflow
// ----------------------------------------------------------------------------
// Overview of operation
// - Select 0 maps compare addresses to compare registers, 1 to auto-reload.
// - Auto-reload contents serve as reload value in 9..16-bit PWM modes.
// - Auto-reload registers have no effect in any other channel mode.
// - Interrupt request follows flag only while overflow irq enable is 1.
// - Flag set on overflow of the low 8..15 counter bits or by software; software clears.
// - With wide reload on, main overflow copies reload to 16-bit PWM compares.
// - Three-bit select sets cycle of 8..15 bits; 16-bit channels ignore it.
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`include "pcc_params.svh"

module pcc_pwm_config #(
    parameter int NUM_CH = `PCC_NUM_CH
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // Register port from the processor
    input  wire pcc_pkg::pcc_sfr_req_s         sfr_req,
    output logic      [7:0]                    sfr_rdata,
    // Main counter, same clock domain
    input  wire logic [15:0]                   ctr_value,
    input  wire logic                          ctr_ovf,
    // Channel modes from the compare modules
    input  wire pcc_pkg::pcc_mode_e [NUM_CH-1:0] ch_mode,
    // Values to the compare modules
    output logic      [NUM_CH-1:0][15:0]       cmp_val,
    output logic      [NUM_CH-1:0][15:0]       reload_val,
    output logic      [NUM_CH-1:0]             reload_use,
    output logic      [3:0]                    cycle_bits,
    // Status and interrupt
    output logic                               cycle_ovf_flag,
    output logic                               wide_pwm_reload_enable,
    output logic                               irq_req
);
    import pcc_pkg::*;

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    generate
        if (NUM_CH < 1 || NUM_CH > `PCC_MAX_CH) begin : g_bad
            $error("pcc_pwm_config: NUM_CH out of range");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Address decode: returns {hit, channel}
    // ------------------------------------------------------------------------
    function automatic logic [3:0] ch_decode(input logic [7:0] addr,
                                             input logic       hi);
        logic [3:0] res;
        logic [7:0] a;
        res = 4'h0;
        for (int i = 0; i < NUM_CH; i++) begin
            a = 8'(`PCC_CMP_LO_BASE + `PCC_CMP_STRIDE * i + (hi ? 1 : 0));
            if (addr == a) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic                     sel_q, sel_d;
    logic                     ovf_ie_q, ovf_ie_d;
    logic                     ovf_flag_q, ovf_flag_d;
    logic                     wide_rl_q, wide_rl_d;
    logic [2:0]               len_sel_q, len_sel_d;
    logic [15:0]              ctr_prev_q, ctr_prev_d;
    logic [7:0]               rdata_q, rdata_d;
    logic                     irq_q, irq_d;
    logic [NUM_CH-1:0][15:0]  cmp_q, cmp_d;
    logic [NUM_CH-1:0][15:0]  rl_out_q, rl_out_d;
    logic [NUM_CH-1:0]        use_q, use_d;
    logic [3:0]               cyc_q, cyc_d;
    logic [NUM_CH-1:0][15:0]  bank_q;

    // Decoded access terms
    logic       cfg_hit;
    logic [3:0] lo_dec, hi_dec;
    logic       cmp_acc;
    logic [2:0] acc_ch;
    logic       acc_hi;
    logic       cycle_wrap;
    logic [15:0] cyc_mask;

    assign cfg_hit = (sfr_req.addr == `PCC_CFG_ADDR);
    assign lo_dec  = ch_decode(sfr_req.addr, 1'b0);
    assign hi_dec  = ch_decode(sfr_req.addr, 1'b1);
    assign cmp_acc = lo_dec[3] | hi_dec[3];
    assign acc_hi  = hi_dec[3];
    assign acc_ch  = hi_dec[3] ? hi_dec[2:0] : lo_dec[2:0];

    // ------------------------------------------------------------------------
    // Hidden reload bank, written only while the select bit is 1
    // ------------------------------------------------------------------------
    pcc_reload_bank #(
        .NUM_CH (NUM_CH)
    ) u_bank (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wr_en    (sfr_req.wr & cmp_acc & sel_q),
        .wr_ch    (acc_ch),
        .wr_hi    (acc_hi),
        .wr_data  (sfr_req.wdata),
        .reload_q (bank_q)
    );

    // ------------------------------------------------------------------------
    // Cycle overflow detection
    // ------------------------------------------------------------------------
    // Low (8+select) bits wrapping from all ones to zero; comparing with the
    // previous sample avoids needing a separate carry from the counter core
    always_comb begin
        cyc_mask   = 16'((17'h00001 << (`PCC_MIN_CYCLE_BITS + 5'(len_sel_q)))
                         - 17'h00001);
        cycle_wrap = ((ctr_prev_q & cyc_mask) == cyc_mask) &&
                     ((ctr_value & cyc_mask) == 16'h0000);
        ctr_prev_d = ctr_value;
    end

    // ------------------------------------------------------------------------
    // Configuration register next state
    // ------------------------------------------------------------------------
    // Hardware set beats a software clear in the same cycle
    always_comb begin
        sel_d      = sel_q;
        ovf_ie_d   = ovf_ie_q;
        wide_rl_d  = wide_rl_q;
        len_sel_d  = len_sel_q;
        ovf_flag_d = ovf_flag_q;
        if (sfr_req.wr && cfg_hit) begin
            sel_d      = sfr_req.wdata[`PCC_SEL_BIT];
            ovf_ie_d   = sfr_req.wdata[`PCC_OVF_IE_BIT];
            wide_rl_d  = sfr_req.wdata[`PCC_WIDE_RL_BIT];
            len_sel_d  = sfr_req.wdata[`PCC_LEN_SEL_MSB:`PCC_LEN_SEL_LSB];
            ovf_flag_d = sfr_req.wdata[`PCC_OVF_FLAG_BIT];
        end
        if (cycle_wrap) begin
            ovf_flag_d = 1'b1;
        end
        irq_d = ovf_ie_d & ovf_flag_d;
        cyc_d = 4'(`PCC_MIN_CYCLE_BITS) + {1'b0, len_sel_d};
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel_q      <= 1'b0;
            ovf_ie_q   <= 1'b0;
            ovf_flag_q <= 1'b0;
            wide_rl_q  <= 1'b0;
            len_sel_q  <= 3'h0;
            irq_q      <= 1'b0;
            cyc_q      <= 4'(`PCC_MIN_CYCLE_BITS);
        end else begin
            sel_q      <= sel_d;
            ovf_ie_q   <= ovf_ie_d;
            ovf_flag_q <= ovf_flag_d;
            wide_rl_q  <= wide_rl_d;
            len_sel_q  <= len_sel_d;
            irq_q      <= irq_d;
            cyc_q      <= cyc_d;
        end
    end

    // ------------------------------------------------------------------------
    // Compare registers and reload outputs
    // ------------------------------------------------------------------------
    // A processor write lands after the overflow copy, so software's value
    // is the one kept when both hit the same cycle
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            cmp_d[i] = cmp_q[i];
            if (wide_rl_q && ctr_ovf && ch_mode[i] == PCC_MODE_PWM16) begin
                cmp_d[i] = bank_q[i];
            end
            if (sfr_req.wr && cmp_acc && !sel_q && acc_ch == 3'(i)) begin
                if (acc_hi) begin
                    cmp_d[i][15:8] = sfr_req.wdata;
                end else begin
                    cmp_d[i][7:0] = sfr_req.wdata;
                end
            end
            // Reload value only offered to 9..16-bit PWM channels
            use_d[i] = (ch_mode[i] == PCC_MODE_PWMN) ||
                       (ch_mode[i] == PCC_MODE_PWM16);
            rl_out_d[i] = use_d[i] ? bank_q[i] : 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmp_q    <= '0;
            rl_out_q <= '0;
            use_q    <= '0;
        end else begin
            cmp_q    <= cmp_d;
            rl_out_q <= rl_out_d;
            use_q    <= use_d;
        end
    end

    // ------------------------------------------------------------------------
    // Read data, held between reads
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_req.rd) begin
            rdata_d = 8'h00;
            if (cfg_hit) begin
                rdata_d = {sel_q, ovf_ie_q, ovf_flag_q, 1'b0, wide_rl_q,
                           len_sel_q} & `PCC_CFG_WMASK;
            end else if (cmp_acc) begin
                if (sel_q) begin
                    rdata_d = acc_hi ? bank_q[acc_ch][15:8]
                                     : bank_q[acc_ch][7:0];
                end else begin
                    rdata_d = acc_hi ? cmp_q[acc_ch][15:8]
                                     : cmp_q[acc_ch][7:0];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q    <= 8'h00;
            ctr_prev_q <= 16'h0000;
        end else begin
            rdata_q    <= rdata_d;
            ctr_prev_q <= ctr_prev_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------------
    assign sfr_rdata              = rdata_q;
    assign cmp_val                = cmp_q;
    assign reload_val             = rl_out_q;
    assign reload_use             = use_q;
    assign cycle_bits             = cyc_q;
    assign cycle_ovf_flag         = ovf_flag_q;
    assign wide_pwm_reload_enable = wide_rl_q;
    assign irq_req                = irq_q;

endmodule // pcc_pwm_config

// file: pcc_params.svh
// Offsets, field positions, reset values and sizes for the PWM configuration block
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define PCC_CFG_ADDR       8'hF7
`define PCC_CMP_LO_BASE    8'hE9
`define PCC_CMP_STRIDE     8'h02

// ----------------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------------
`define PCC_SEL_BIT        7
`define PCC_OVF_IE_BIT     6
`define PCC_OVF_FLAG_BIT   5
`define PCC_WIDE_RL_BIT    3
`define PCC_LEN_SEL_MSB    2
`define PCC_LEN_SEL_LSB    0
`define PCC_CFG_RESET      8'h00
`define PCC_CFG_WMASK      8'hEF

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define PCC_MIN_CYCLE_BITS 5'h08
`define PCC_NUM_CH         3
`define PCC_MAX_CH         8

`endif

// file: pcc_pkg.sv
// Types shared by the PWM configuration block
package pcc_pkg;

    // ------------------------------------------------------------------------
    // Channel mode as seen by this block
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PCC_MODE_OTHER = 2'b00,
        PCC_MODE_PWM8  = 2'b01,
        PCC_MODE_PWMN  = 2'b10,
        PCC_MODE_PWM16 = 2'b11
    } pcc_mode_e;

    // ------------------------------------------------------------------------
    // Register port request, one access per strobe
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } pcc_sfr_req_s;

endpackage

// file: pcc_reload_bank.sv
// Hidden auto-reload registers, one 16-bit word per channel
`timescale 1ns/10ps
`include "pcc_params.svh"

module pcc_reload_bank #(
    parameter int NUM_CH = `PCC_NUM_CH
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Byte write port
    input  wire logic                  wr_en,
    input  wire logic [2:0]            wr_ch,
    input  wire logic                  wr_hi,
    input  wire logic [7:0]            wr_data,
    // Stored values
    output logic      [NUM_CH-1:0][15:0] reload_q
);
    import pcc_pkg::*;

    logic [NUM_CH-1:0][15:0] reload_d;

    // ------------------------------------------------------------------------
    // Per-channel storage
    // ------------------------------------------------------------------------
    generate
        if (NUM_CH < 1 || NUM_CH > `PCC_MAX_CH) begin : g_bad
            $error("pcc_reload_bank: NUM_CH out of range");
        end
    endgenerate

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            // Byte merge for the addressed channel only
            always_comb begin
                reload_d[g] = reload_q[g];
                if (wr_en && wr_ch == 3'(g)) begin
                    if (wr_hi) begin
                        reload_d[g][15:8] = wr_data;
                    end else begin
                        reload_d[g][7:0] = wr_data;
                    end
                end
            end

            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    reload_q[g] <= 16'h0000;
                end else begin
                    reload_q[g] <= reload_d[g];
                end
            end
        end
    endgenerate

endmodule // pcc_reload_bank

// file: pcc_pwm_config_monitor.sv
// Port-level assertions for the PWM configuration block
`timescale 1ns/10ps
`include "pcc_params.svh"

module pcc_pwm_config_monitor #(
    parameter int NUM_CH = `PCC_NUM_CH
) (
    // Clock and reset
    input wire logic                            clk_sys,
    input wire logic                            rst,
    // Register port
    input wire pcc_pkg::pcc_sfr_req_s           sfr_req,
    input wire logic [7:0]                      sfr_rdata,
    // Counter side and channel modes
    input wire logic [15:0]                     ctr_value,
    input wire logic                            ctr_ovf,
    input wire pcc_pkg::pcc_mode_e [NUM_CH-1:0] ch_mode,
    // Outputs under watch
    input wire logic [NUM_CH-1:0][15:0]         cmp_val,
    input wire logic [NUM_CH-1:0][15:0]         reload_val,
    input wire logic [NUM_CH-1:0]               reload_use,
    input wire logic [3:0]                      cycle_bits,
    input wire logic                            cycle_ovf_flag,
    input wire logic                            wide_pwm_reload_enable,
    input wire logic                            irq_req
);
    import pcc_pkg::*;

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [15:0]       len_mask;
    logic [NUM_CH-1:0] wants_reload;
    logic              stray_reload;
    logic              cfg_wr;

    // Wrap mask follows the registered length, so tests keep it steady
    always_comb begin
        len_mask = (16'h0001 << cycle_bits) - 16'h0001;
        stray_reload = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            wants_reload[i] = ch_mode[i] inside {PCC_MODE_PWMN, PCC_MODE_PWM16};
            stray_reload |= !reload_use[i] && (reload_val[i] != 16'h0000);
        end
    end
    assign cfg_wr = sfr_req.wr && (sfr_req.addr == `PCC_CFG_ADDR);

    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    irq_from_flag_a: assert property (cfg_wr && sfr_req.wdata[5]
        |=> irq_req == $past(sfr_req.wdata[6])) else $error("irq mismatch");
    flag_clear_cause_a: assert property ($fell(cycle_ovf_flag)
        |-> $past(rst) || $past(cfg_wr && !sfr_req.wdata[5]))
        else $error("flag cleared without write");
    wrap_sets_flag_a: assert property (($past(ctr_value) & len_mask)
        == len_mask && (ctr_value & len_mask) == 16'h0000 |=> cycle_ovf_flag)
        else $error("wrap did not set flag");
    cycle_len_a: assert property (cfg_wr
        |=> cycle_bits == 4'h8 + $past(sfr_req.wdata[2:0]))
        else $error("cycle length wrong");
    reload_use_a: assert property (!$past(rst)
        |-> reload_use == $past(wants_reload)) else $error("reload use wrong");
    reload_idle_a: assert property (!stray_reload)
        else $error("reload value leaks to idle channel");
    wide_copy_a: assert property (ctr_ovf && wide_pwm_reload_enable
        && ch_mode[0] == PCC_MODE_PWM16 && reload_use[0] && !sfr_req.wr
        |=> cmp_val[0] == $past(reload_val[0])) else $error("copy missing");
    cfg_bit4_zero_a: assert property (sfr_req.rd
        && sfr_req.addr == `PCC_CFG_ADDR |=> !sfr_rdata[4])
        else $error("config bit 4 not zero");
    rdata_hold_a: assert property (!sfr_req.rd && !rst
        |=> $stable(sfr_rdata)) else $error("read data moved");
endmodule // pcc_pwm_config_monitor

bind pcc_pwm_config pcc_pwm_config_monitor #(.NUM_CH(NUM_CH)) mon_u (
    .clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .ctr_value(ctr_value), .ctr_ovf(ctr_ovf), .ch_mode(ch_mode),
    .cmp_val(cmp_val), .reload_val(reload_val), .reload_use(reload_use),
    .cycle_bits(cycle_bits), .cycle_ovf_flag(cycle_ovf_flag),
    .wide_pwm_reload_enable(wide_pwm_reload_enable), .irq_req(irq_req)
);

// file: pcc_pwm_config_tb_top.sv
// Self-checking bench for the PWM configuration block
`timescale 1ns/10ps
`include "pcc_params.svh"

module pcc_pwm_config_tb_top;
    import pcc_pkg::*;

    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic                              clk_sys;
    logic                              rst;
    pcc_sfr_req_s                      sfr_req;
    logic [7:0]                        sfr_rdata;
    logic [15:0]                       ctr_value;
    logic                              ctr_ovf;
    pcc_mode_e [`PCC_NUM_CH-1:0]       ch_mode;
    logic [`PCC_NUM_CH-1:0][15:0]      cmp_val;
    logic [`PCC_NUM_CH-1:0][15:0]      reload_val;
    logic [`PCC_NUM_CH-1:0]            reload_use;
    logic [3:0]                        cycle_bits;
    logic                              flag;
    logic                              wide_en;
    logic                              irq_req;
    int                                errors;
    int                                n_checks;

    pcc_pwm_config #(.NUM_CH(`PCC_NUM_CH)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .ctr_value(ctr_value), .ctr_ovf(ctr_ovf),
        .ch_mode(ch_mode), .cmp_val(cmp_val), .reload_val(reload_val),
        .reload_use(reload_use), .cycle_bits(cycle_bits),
        .cycle_ovf_flag(flag), .wide_pwm_reload_enable(wide_en),
        .irq_req(irq_req)
    );

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        cyc(1);
        sfr_req = '0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                      input string what);
        sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        cyc(1);
        sfr_req = '0;
        chk(what, {8'h00, exp}, {8'h00, sfr_rdata});
        cyc(1);
    endtask
    task automatic pulse_ovf();
        ctr_ovf = 1'b1;
        cyc(1);
        ctr_ovf = 1'b0;
        cyc(1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_reset();
        chk("cycle_bits", 16'h0008, 16'(cycle_bits));
        chk("irq_req", 16'h0000, 16'(irq_req));
        chk("flag reset", 16'h0000, 16'(flag));
        chk("wide enable reset", 16'h0000, 16'(wide_en));
        rd(`PCC_CFG_ADDR, 8'h00, "cfg reset");
    endtask
    task automatic s_cfg();
        wr(`PCC_CFG_ADDR, 8'hFF);
        rd(`PCC_CFG_ADDR, `PCC_CFG_WMASK, "cfg all ones");
        chk("cycle_bits max", 16'h000F, 16'(cycle_bits));
        chk("wide enable", 16'h0001, 16'(wide_en));
        chk("irq enabled", 16'h0001, 16'(irq_req));
        wr(`PCC_CFG_ADDR, 8'h40);
        chk("flag cleared", 16'h0000, 16'(flag));
        chk("irq cleared", 16'h0000, 16'(irq_req));
        wr(`PCC_CFG_ADDR, 8'h20);
        chk("flag by write", 16'h0001, 16'(flag));
        chk("irq masked", 16'h0000, 16'(irq_req));
        wr(`PCC_CFG_ADDR, 8'h00);
    endtask
    task automatic s_select();
        wr(8'hE9, 8'h11);
        wr(8'hEA, 8'h22);
        wr(`PCC_CFG_ADDR, 8'h80);
        wr(8'hE9, 8'h33);
        wr(8'hEA, 8'h44);
        rd(8'hE9, 8'h33, "reload low");
        chk("compare kept", 16'h2211, cmp_val[0]);
        wr(`PCC_CFG_ADDR, 8'h00);
        rd(8'hEA, 8'h22, "compare high");
        rd(8'hF0, 8'h00, "unmapped");
    endtask
    // Every channel mode; leaves channel 0 in 16-bit PWM
    task automatic s_modes();
        for (int m = 0; m < 4; m++) begin
            ch_mode[0] = pcc_mode_e'(m);
            cyc(2);
            chk("reload_val", (m >= 2) ? 16'h4433 : 16'h0000,
                reload_val[0]);
            chk("reload_use", 16'(m >= 2), 16'(reload_use[0]));
        end
    endtask
    task automatic s_copy();
        wr(`PCC_CFG_ADDR, 8'h08);
        pulse_ovf();
        chk("copy done", 16'h4433, cmp_val[0]);
        wr(`PCC_CFG_ADDR, 8'h00);
        wr(8'hE9, 8'h11);
        wr(8'hEA, 8'h22);
        pulse_ovf();
        chk("no copy", 16'h2211, cmp_val[0]);
    endtask
    // Each length: counter low bits run all ones to all zeros
    task automatic s_wrap();
        for (int n = 0; n < 8; n++) begin
            // Interrupt enabled so the hardware set also shows on irq_req
            wr(`PCC_CFG_ADDR, 8'h40 | 8'(n));
            chk("cycle_bits", 16'(8 + n), 16'(cycle_bits));
            ctr_value = (16'h0001 << (8 + n)) - 16'h0001;
            cyc(1);
            chk("flag early", 16'h0000, 16'(flag));
            chk("irq early", 16'h0000, 16'(irq_req));
            ctr_value = 16'h0001 << (8 + n);
            cyc(1);
            chk("flag on wrap", 16'h0001, 16'(flag));
            chk("irq on wrap", 16'h0001, 16'(irq_req));
            ctr_value = 16'h0000;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence, with a second reset after the last scenario
    initial begin
        errors = 0;
        n_checks = 0;
        rst = 1'b1;
        sfr_req = '0;
        ctr_value = 16'h0000;
        ctr_ovf = 1'b0;
        foreach (ch_mode[i]) ch_mode[i] = PCC_MODE_OTHER;
        cyc(3);
        rst = 1'b0;
        cyc(1);
        s_reset();
        s_cfg();
        s_select();
        s_modes();
        s_copy();
        s_wrap();
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        cyc(1);
        s_reset();
        print_verdict();
    end
endmodule // pcc_pwm_config_tb_top
